// *** hw/fmc_pkg.sv ***
// What this block does
// - word bits B10..B9 pick left, right, format/mute or interface/clock register.
// - left register holds the left code in B7..B0 and left load in B8.
// - right register holds the right code in B7..B0 and right load in B8.
// - gain is 0.5 dB times code minus 255; code 00 mutes fully.
// - common bit B2 set makes the left code drive both attenuators.
// - left load applies left code, right gets left or stored right code.
// - left write without load stores the code, left level unchanged.
// - right load sets right from right or left code, left from stored left.
// - right write without load stores the code, right level unchanged.
// - format/mute bit B0 low turns soft mute on, high turns it off.
// - format/mute bit B1 high turns de-emphasis on.
// - format bit with width field B4..B3 selects input format; 11x reserved.
// - output width field B6..B5 gives 16, 18, 20 or 24 bits.
// - interface bit B0 low selects standard formats, high the I2S formats.
// - interface bit B1 inverts which frame clock level means left.
// - interface bit B3 low gives sharp roll-off, high slow roll-off.
// - interface bit B5 high halves the clock output frequency.
// - interface bits B7..B6 give de-emphasis rate 44.1, reserved, 48, 32 kHz.
package fmc_pkg;

	// ==========================================================
	// control word layout
	localparam int FMC_WORD_W = 16;
	localparam int FMC_ADDR_MSB = 10;
	localparam int FMC_ADDR_LSB = 9;
	localparam int FMC_LOAD_BIT = 8;
	localparam int FMC_CODE_MSB = 7;
	localparam int FMC_CODE_LSB = 0;
	localparam logic [1:0] FMC_ADDR_LEFT = 2'h0;
	localparam logic [1:0] FMC_ADDR_RIGHT = 2'h1;
	localparam logic [1:0] FMC_ADDR_FMT = 2'h2;
	localparam logic [1:0] FMC_ADDR_IFC = 2'h3;

	// ==========================================================
	// format/mute register fields
	localparam int FMC_MUTE_BIT = 0;
	localparam int FMC_DEEMPH_BIT = 1;
	localparam int FMC_IN_WIDTH_MSB = 4;
	localparam int FMC_IN_WIDTH_LSB = 3;
	localparam int FMC_OUT_WIDTH_MSB = 6;
	localparam int FMC_OUT_WIDTH_LSB = 5;

	// ==========================================================
	// interface/clock register fields
	localparam int FMC_FMTSEL_BIT = 0;
	localparam int FMC_POL_BIT = 1;
	localparam int FMC_COMMON_BIT = 2;
	localparam int FMC_ROLL_BIT = 3;
	localparam int FMC_CKHALF_BIT = 5;
	localparam int FMC_RATE_SEL_MSB = 7;
	localparam int FMC_RATE_SEL_LSB = 6;

	// ==========================================================
	// values after reset
	localparam logic [7:0] FMC_CODE_RST = 8'hFF;
	localparam logic FMC_MUTE_N_RST = 1'h1;
	localparam logic [1:0] FMC_FIELD2_RST = 2'h0;
	localparam logic FMC_BIT_RST = 1'h0;

	// ==========================================================
	// attenuation arithmetic and width figures
	localparam logic signed [8:0] FMC_GAIN_OFFSET = 9'sh0FF;
	localparam logic signed [8:0] FMC_GAIN_RST = 9'sh000;
	localparam logic [7:0] FMC_CODE_MUTE = 8'h00;
	localparam logic [4:0] FMC_OUT_BITS16 = 5'h10;
	localparam logic [4:0] FMC_OUT_BITS18 = 5'h12;
	localparam logic [4:0] FMC_OUT_BITS20 = 5'h14;
	localparam logic [4:0] FMC_OUT_BITS24 = 5'h18;

	// ==========================================================
	// input formats and de-emphasis rates
	typedef enum logic [2:0] {
		FMC_IN_STD16 = 3'h0,
		FMC_IN_STD20 = 3'h1,
		FMC_IN_STD24 = 3'h2,
		FMC_IN_LJ24 = 3'h3,
		FMC_IN_I2S16 = 3'h4,
		FMC_IN_I2S24 = 3'h5,
		FMC_IN_RSVD = 3'h7
	} fmc_in_fmt_e;

	typedef enum logic [1:0] {
		FMC_RATE_44K1 = 2'h0,
		FMC_RATE_RSVD = 2'h1,
		FMC_RATE_48K = 2'h2,
		FMC_RATE_32K = 2'h3
	} fmc_rate_e;

endpackage : fmc_pkg

// *** hw/fmc_level_if.sv ***
`timescale 1ns/1ps
// ==========================================================
// one channel's level request and the level it holds
interface fmc_level_if;
	logic load;
	logic [7:0] value;
	logic [7:0] level;
	logic full_mute;
	logic signed [8:0] gain;

	modport drive (output load, output value, input level, input full_mute, input gain);
	modport hold (input load, input value, output level, output full_mute, output gain);
endinterface : fmc_level_if

// *** hw/fmc_level_hold.sv ***
`timescale 1ns/1ps
// ==========================================================
// holds the applied attenuation of one channel
module fmc_level_hold (
	input wire logic core_clk, // 20 MHz clock
	input wire logic sys_rst, // async reset, high
	fmc_level_if.hold lv // level request and held level
);
	import fmc_pkg::*;

	logic [7:0] level_r;
	logic full_mute_r;
	logic signed [8:0] gain_r;

	// level, mute flag and gain move together so the filter never sees a mix
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			level_r <= FMC_CODE_RST;
			full_mute_r <= FMC_BIT_RST;
			gain_r <= FMC_GAIN_RST;
		end else if (lv.load) begin
			level_r <= lv.value;
			full_mute_r <= (lv.value == FMC_CODE_MUTE);
			gain_r <= $signed({1'b0, lv.value}) - FMC_GAIN_OFFSET;
		end
	end

	assign lv.level = level_r;
	assign lv.full_mute = full_mute_r;
	assign lv.gain = gain_r;

	// ==========================================================
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	gain_map_a: assert property (lv.load |=>
		(lv.gain == $signed({1'b0, $past(lv.value)}) - 9'sh0FF)
		&& (lv.full_mute == ($past(lv.value) == 8'h00)))
		else $error("gain or full mute does not match loaded code");

	hold_still_a: assert property (!lv.load |=> $stable(lv.level) && $stable(lv.gain))
		else $error("held level moved without a load");

endmodule : fmc_level_hold

// *** hw/fmc_top.sv ***
`timescale 1ns/1ps
// ==========================================================
// mode control register bank: decodes control words into settings
module fmc_top (
	input wire logic core_clk, // 20 MHz clock
	input wire logic sys_rst, // async reset, high
	input wire logic [15:0] ctl_word, // received control word
	input wire logic ctl_word_valid, // one-cycle strobe, word complete
	output logic [7:0] left_atten_code, // stored left code
	output logic [7:0] right_atten_code, // stored right code
	output logic [7:0] left_level, // applied left code
	output logic [7:0] right_level, // applied right code
	output logic left_full_mute, // left code 00 applied
	output logic right_full_mute, // right code 00 applied
	output logic signed [8:0] left_gain_halfdb, // left gain in 0.5 dB steps
	output logic signed [8:0] right_gain_halfdb, // right gain in 0.5 dB steps
	output logic soft_silence_n, // low: soft mute on
	output logic deemphasis_enable, // high: de-emphasis on
	output logic [1:0] input_width_field, // raw input width field
	output logic [1:0] output_width_field, // raw output width field
	output fmc_pkg::fmc_in_fmt_e input_format, // decoded input format
	output logic input_format_reserved, // reserved format selected
	output logic [4:0] output_word_bits, // output word length in bits
	output logic i2s_select, // high: I2S input formats
	output logic frame_clock_polarity, // high: low frame clock is left
	output logic common_attenuation, // high: left code drives both
	output logic slow_rolloff_select, // high: slow roll-off
	output logic clock_out_halve, // high: clock out at half rate
	output logic [1:0] deemphasis_rate_select, // raw rate field
	output fmc_pkg::fmc_rate_e deemphasis_rate, // decoded rate
	output logic deemphasis_rate_reserved // reserved rate selected
);
	import fmc_pkg::*;

	// ==========================================================
	// word decode
	logic [1:0] word_addr;
	logic [7:0] word_code;
	logic word_load;
	logic wr_left;
	logic wr_right;
	logic wr_fmt;
	logic wr_ifc;
	logic left_apply;
	logic right_apply;

	// address bits pick exactly one register per strobe
	assign word_addr = ctl_word[FMC_ADDR_MSB:FMC_ADDR_LSB];
	assign word_code = ctl_word[FMC_CODE_MSB:FMC_CODE_LSB];
	assign word_load = ctl_word[FMC_LOAD_BIT];
	assign wr_left = ctl_word_valid && (word_addr == FMC_ADDR_LEFT);
	assign wr_right = ctl_word_valid && (word_addr == FMC_ADDR_RIGHT);
	assign wr_fmt = ctl_word_valid && (word_addr == FMC_ADDR_FMT);
	assign wr_ifc = ctl_word_valid && (word_addr == FMC_ADDR_IFC);
	assign left_apply = wr_left && word_load;
	assign right_apply = wr_right && word_load;

	// ==========================================================
	// stored registers
	logic [7:0] left_code_r;
	logic [7:0] right_code_r;
	logic mute_n_r;
	logic deemph_r;
	logic [1:0] in_width_r;
	logic [1:0] out_width_r;
	logic fmtsel_r;
	logic pol_r;
	logic common_r;
	logic roll_r;
	logic ckhalf_r;
	logic [1:0] rate_sel_r;

	// attenuation codes: bits B15..B11 never reach a flop
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			left_code_r <= FMC_CODE_RST;
			right_code_r <= FMC_CODE_RST;
		end else begin
			if (wr_left) begin
				left_code_r <= word_code;
			end
			if (wr_right) begin
				right_code_r <= word_code;
			end
		end
	end

	// format/mute register; unused positions are dropped
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			mute_n_r <= FMC_MUTE_N_RST;
			deemph_r <= FMC_BIT_RST;
			in_width_r <= FMC_FIELD2_RST;
			out_width_r <= FMC_FIELD2_RST;
		end else if (wr_fmt) begin
			mute_n_r <= ctl_word[FMC_MUTE_BIT];
			deemph_r <= ctl_word[FMC_DEEMPH_BIT];
			in_width_r <= ctl_word[FMC_IN_WIDTH_MSB:FMC_IN_WIDTH_LSB];
			out_width_r <= ctl_word[FMC_OUT_WIDTH_MSB:FMC_OUT_WIDTH_LSB];
		end
	end

	// interface/clock register
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			fmtsel_r <= FMC_BIT_RST;
			pol_r <= FMC_BIT_RST;
			common_r <= FMC_BIT_RST;
			roll_r <= FMC_BIT_RST;
			ckhalf_r <= FMC_BIT_RST;
			rate_sel_r <= FMC_FIELD2_RST;
		end else if (wr_ifc) begin
			fmtsel_r <= ctl_word[FMC_FMTSEL_BIT];
			pol_r <= ctl_word[FMC_POL_BIT];
			common_r <= ctl_word[FMC_COMMON_BIT];
			roll_r <= ctl_word[FMC_ROLL_BIT];
			ckhalf_r <= ctl_word[FMC_CKHALF_BIT];
			rate_sel_r <= ctl_word[FMC_RATE_SEL_MSB:FMC_RATE_SEL_LSB];
		end
	end

	// ==========================================================
	// applied levels
	fmc_level_if left_if ();
	fmc_level_if right_if ();

	// a load on either channel refreshes both, as the two loads are meant to
	// set the pair at once; common mode is read from the stored bit, so a
	// change of mode only takes effect at the next load
	always_comb begin
		left_if.load = left_apply || right_apply;
		right_if.load = left_apply || right_apply;
		if (left_apply) begin
			left_if.value = word_code;
			right_if.value = common_r ? word_code : right_code_r;
		end else begin
			left_if.value = left_code_r;
			right_if.value = common_r ? left_code_r : word_code;
		end
	end

	// writes without load leave the holders alone
	fmc_level_hold u_left_hold (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.lv(left_if.hold)
	);

	fmc_level_hold u_right_hold (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.lv(right_if.hold)
	);

	// ==========================================================
	// decoded settings, registered so every data output leaves a flop
	fmc_in_fmt_e in_fmt_r;
	logic in_fmt_rsvd_r;
	logic [4:0] out_bits_r;
	fmc_rate_e rate_r;
	logic rate_rsvd_r;

	// input format from format bit and width field; one cycle behind the field
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			in_fmt_r <= FMC_IN_STD16;
			in_fmt_rsvd_r <= FMC_BIT_RST;
		end else begin
			case ({fmtsel_r, in_width_r})
				3'h0: in_fmt_r <= FMC_IN_STD16;
				3'h1: in_fmt_r <= FMC_IN_STD20;
				3'h2: in_fmt_r <= FMC_IN_STD24;
				3'h3: in_fmt_r <= FMC_IN_LJ24;
				3'h4: in_fmt_r <= FMC_IN_I2S16;
				3'h5: in_fmt_r <= FMC_IN_I2S24;
				default: in_fmt_r <= FMC_IN_RSVD;
			endcase
			in_fmt_rsvd_r <= fmtsel_r && in_width_r[1];
		end
	end

	// output word length in bits
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			out_bits_r <= FMC_OUT_BITS16;
		end else begin
			case (out_width_r)
				2'h0: out_bits_r <= FMC_OUT_BITS16;
				2'h1: out_bits_r <= FMC_OUT_BITS18;
				2'h2: out_bits_r <= FMC_OUT_BITS20;
				default: out_bits_r <= FMC_OUT_BITS24;
			endcase
		end
	end

	// de-emphasis rate; the reserved code is flagged, not remapped
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rate_r <= FMC_RATE_44K1;
			rate_rsvd_r <= FMC_BIT_RST;
		end else begin
			case (rate_sel_r)
				2'h0: rate_r <= FMC_RATE_44K1;
				2'h1: rate_r <= FMC_RATE_RSVD;
				2'h2: rate_r <= FMC_RATE_48K;
				default: rate_r <= FMC_RATE_32K;
			endcase
			rate_rsvd_r <= (rate_sel_r == 2'h1);
		end
	end

	// ==========================================================
	// outputs
	assign left_atten_code = left_code_r;
	assign right_atten_code = right_code_r;
	assign left_level = left_if.level;
	assign right_level = right_if.level;
	assign left_full_mute = left_if.full_mute;
	assign right_full_mute = right_if.full_mute;
	assign left_gain_halfdb = left_if.gain;
	assign right_gain_halfdb = right_if.gain;
	assign soft_silence_n = mute_n_r;
	assign deemphasis_enable = deemph_r;
	assign input_width_field = in_width_r;
	assign output_width_field = out_width_r;
	assign input_format = in_fmt_r;
	assign input_format_reserved = in_fmt_rsvd_r;
	assign output_word_bits = out_bits_r;
	assign i2s_select = fmtsel_r;
	assign frame_clock_polarity = pol_r;
	assign common_attenuation = common_r;
	assign slow_rolloff_select = roll_r;
	assign clock_out_halve = ckhalf_r;
	assign deemphasis_rate_select = rate_sel_r;
	assign deemphasis_rate = rate_r;
	assign deemphasis_rate_reserved = rate_rsvd_r;

	// ==========================================================
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	sequence s_left_load;
		ctl_word_valid && (ctl_word[10:9] == 2'h0) && ctl_word[8];
	endsequence

	sequence s_right_load;
		ctl_word_valid && (ctl_word[10:9] == 2'h1) && ctl_word[8];
	endsequence

	sequence s_quiet2;
		!ctl_word_valid [*2];
	endsequence

	addr_decode_a: assert property (ctl_word_valid && (ctl_word[10:9] == 2'h0)
		|=> (left_atten_code == $past(ctl_word[7:0])) && $stable(right_atten_code))
		else $error("left write did not land in the left register");

	right_store_a: assert property (ctl_word_valid && (ctl_word[10:9] == 2'h1)
		|=> (right_atten_code == $past(ctl_word[7:0])) && $stable(left_atten_code))
		else $error("right write did not land in the right register");

	left_apply_a: assert property (s_left_load |=>
		(left_level == $past(ctl_word[7:0]))
		&& (right_level == ($past(common_attenuation) ? $past(ctl_word[7:0])
			: $past(right_atten_code))))
		else $error("left load applied wrong levels");

	left_keep_a: assert property (ctl_word_valid && (ctl_word[10:9] == 2'h0)
		&& !ctl_word[8] |=> $stable(left_level) && $stable(right_level))
		else $error("left write without load moved a level");

	right_apply_a: assert property (s_right_load |=>
		(left_level == $past(left_atten_code))
		&& (right_level == ($past(common_attenuation) ? $past(left_atten_code)
			: $past(ctl_word[7:0]))))
		else $error("right load applied wrong levels");

	right_keep_a: assert property (ctl_word_valid && (ctl_word[10:9] == 2'h1)
		&& !ctl_word[8] |=> $stable(right_level) && $stable(left_level))
		else $error("right write without load moved a level");

	common_both_a: assert property (s_left_load ##0 common_attenuation
		|=> right_level == left_level)
		else $error("common mode left channels apart");

	fmt_fields_a: assert property (ctl_word_valid && (ctl_word[10:9] == 2'h2)
		|=> (soft_silence_n == $past(ctl_word[0])) && (deemphasis_enable == $past(ctl_word[1]))
		&& (output_width_field == $past(ctl_word[6:5]))
		&& (input_width_field == $past(ctl_word[4:3])))
		else $error("format/mute fields not stored");

	ifc_fields_a: assert property (ctl_word_valid && (ctl_word[10:9] == 2'h3)
		|=> (frame_clock_polarity == $past(ctl_word[1])) && (slow_rolloff_select == $past(ctl_word[3]))
		&& (clock_out_halve == $past(ctl_word[5])) && (common_attenuation == $past(ctl_word[2]))
		&& (i2s_select == $past(ctl_word[0])) && (deemphasis_rate_select == $past(ctl_word[7:6])))
		else $error("interface/clock fields not stored");

	in_fmt_a: assert property (s_quiet2 |->
		(input_format_reserved == (i2s_select && input_width_field[1]))
		&& (input_format == (input_format_reserved ? FMC_IN_RSVD
			: fmc_in_fmt_e'({i2s_select, input_width_field}))))
		else $error("input format decode wrong");

	out_bits_a: assert property (s_quiet2 |->
		output_word_bits == ((output_width_field == 2'h0) ? 5'h10
			: (output_width_field == 2'h1) ? 5'h12
			: (output_width_field == 2'h2) ? 5'h14 : 5'h18))
		else $error("output word length decode wrong");

	rate_dec_a: assert property (s_quiet2 |->
		(deemphasis_rate_reserved == (deemphasis_rate_select == 2'h1))
		&& (deemphasis_rate == fmc_rate_e'(deemphasis_rate_select)))
		else $error("de-emphasis rate decode wrong");

	retain_regs_a: assert property (!ctl_word_valid |=>
		$stable(soft_silence_n) && $stable(i2s_select) && $stable(deemphasis_rate_select)
		&& $stable(left_atten_code) && $stable(right_atten_code))
		else $error("register changed with no write");

endmodule : fmc_top

// *** verif/fmc_host_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// host side of the control port: hands complete words to the block
module fmc_host_model (
	input wire logic core_clk, // 20 MHz clock
	output logic [15:0] ctl_word, // word handed over
	output logic ctl_word_valid // one strobe per word
);
	// quiet at time zero, strobe low
	initial begin
		ctl_word = 16'h0000;
		ctl_word_valid = 1'b0;
	end

	// one word, B15 as bit 15; the top five bits are always reserved, so cleared
	task automatic send(input logic [15:0] w);
		@(negedge core_clk);
		ctl_word <= w & 16'h07FF;
		ctl_word_valid <= 1'b1;
		@(posedge core_clk);
	endtask : send

	// same, but reserved positions kept as given, for the ignore test
	task automatic send_raw(input logic [15:0] w);
		@(negedge core_clk);
		ctl_word <= w;
		ctl_word_valid <= 1'b1;
		@(posedge core_clk);
	endtask : send_raw

	// released bus shows the inverse so a stale word is never mistaken for data
	task automatic idle();
		@(negedge core_clk);
		ctl_word_valid <= 1'b0;
		ctl_word <= ~ctl_word;
	endtask : idle
endmodule : fmc_host_model

// *** verif/testbench.sv ***
`timescale 1ns/1ps
// ==========================================================
// self-checking bench for the mode control register bank
module testbench;
	import fmc_pkg::*;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [15:0] ctl_word;
	logic ctl_word_valid;
	logic [7:0] lac, rac, llv, rlv;
	logic lfm, rfm, ssn, dee, i2s, pol, com, slo, ckh, ifr, drr;
	logic signed [8:0] lg, rg;
	logic [1:0] iwf, owf, sfr;
	fmc_in_fmt_e ifm;
	fmc_rate_e drt;
	logic [4:0] owb;
	int fails = 0;
	int tests_run = 0;

	// 50 ns period
	always #25 core_clk = ~core_clk;

	fmc_host_model fmc_host_model_inst (.core_clk(core_clk), .ctl_word(ctl_word),
		.ctl_word_valid(ctl_word_valid));

	fmc_top fmc_top_inst (.core_clk(core_clk), .sys_rst(sys_rst), .ctl_word(ctl_word),
		.ctl_word_valid(ctl_word_valid), .left_atten_code(lac), .right_atten_code(rac),
		.left_level(llv), .right_level(rlv), .left_full_mute(lfm), .right_full_mute(rfm),
		.left_gain_halfdb(lg), .right_gain_halfdb(rg), .soft_silence_n(ssn),
		.deemphasis_enable(dee), .input_width_field(iwf), .output_width_field(owf),
		.input_format(ifm), .input_format_reserved(ifr), .output_word_bits(owb),
		.i2s_select(i2s), .frame_clock_polarity(pol), .common_attenuation(com),
		.slow_rolloff_select(slo), .clock_out_halve(ckh), .deemphasis_rate_select(sfr),
		.deemphasis_rate(drt), .deemphasis_rate_reserved(drr));

	// ==========================================================
	// compare tasks, one per kind of result
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_val

	task automatic chk_bit(input logic got, input logic exp);
		chk_val({15'h0000, got}, {15'h0000, exp});
	endtask : chk_bit

	// gain in half-dB steps, worked out here from the code
	function automatic logic [15:0] gain_of(input logic [7:0] c);
		logic [8:0] g;
		g = {1'b0, c} - 9'h0FF;
		return {{7{g[8]}}, g};
	endfunction : gain_of

	// attenuation word: address, load bit, code
	function automatic logic [15:0] w_att(input logic [1:0] a, input logic ld, input logic [7:0] c);
		return {5'h00, a, ld, c};
	endfunction : w_att

	// checks both applied levels with their gains and mute flags
	task automatic chk_levels(input logic [7:0] el, input logic [7:0] er);
		chk_val({8'h00, llv}, {8'h00, el});
		chk_val({8'h00, rlv}, {8'h00, er});
		chk_val({{7{lg[8]}}, lg}, gain_of(el));
		chk_val({{7{rg[8]}}, rg}, gain_of(er));
		chk_bit(lfm, el == 8'h00);
		chk_bit(rfm, er == 8'h00);
	endtask : chk_levels

	// ==========================================================
	// scenarios
	task automatic t_reset();
		chk_levels(8'hFF, 8'hFF);
		chk_bit(ssn, 1'b1);
		chk_val({11'h000, owb}, 16'h0010);
		chk_val({13'h0000, ifm}, 16'h0000);
	endtask : t_reset

	// independent mode: loads, held levels, back to back words
	task automatic t_independent();
		fmc_host_model_inst.send(w_att(2'h1, 1'b0, 8'h40));
		fmc_host_model_inst.send(w_att(2'h0, 1'b1, 8'h80));
		fmc_host_model_inst.send(w_att(2'h0, 1'b0, 8'h00));
		fmc_host_model_inst.idle();
		chk_val({8'h00, lac}, 16'h0000);
		chk_val({8'h00, rac}, 16'h0040);
		chk_levels(8'h80, 8'h40);
		fmc_host_model_inst.send(w_att(2'h1, 1'b1, 8'h10));
		fmc_host_model_inst.idle();
		chk_levels(8'h00, 8'h10);
		fmc_host_model_inst.send(w_att(2'h1, 1'b0, 8'h01));
		fmc_host_model_inst.idle();
		chk_levels(8'h00, 8'h10);
	endtask : t_independent

	// common mode: left code feeds both channels on either load
	task automatic t_common();
		fmc_host_model_inst.send({5'h00, 2'h3, 9'h004});
		fmc_host_model_inst.send(w_att(2'h0, 1'b1, 8'h33));
		fmc_host_model_inst.idle();
		chk_bit(com, 1'b1);
		chk_levels(8'h33, 8'h33);
		fmc_host_model_inst.send(w_att(2'h1, 1'b1, 8'h77));
		fmc_host_model_inst.idle();
		chk_levels(8'h33, 8'h33);
		chk_val({8'h00, rac}, 16'h0077);
	endtask : t_common

	// every input format, width, mute and de-emphasis setting
	task automatic t_formats();
		logic [15:0] ef [8];
		logic [15:0] eo [4];
		ef = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'h0007, 16'h0007};
		eo = '{16'h0010, 16'h0012, 16'h0014, 16'h0018};
		for (int k = 0; k < 8; k++) begin
			fmc_host_model_inst.send({5'h00, 2'h3, 8'h00, k[2]});
			fmc_host_model_inst.send({5'h00, 2'h2, 2'h0, k[1:0], k[1:0], 1'b0, k[1], k[0]});
			fmc_host_model_inst.idle();
			chk_bit(i2s, k[2]);
			chk_val({14'h0000, iwf}, {14'h0000, k[1:0]});
			chk_val({14'h0000, owf}, {14'h0000, k[1:0]});
			chk_bit(ssn, k[0]);
			chk_bit(dee, k[1]);
			@(negedge core_clk);
			chk_val({13'h0000, ifm}, ef[k]);
			chk_bit(ifr, k >= 6);
			chk_val({11'h000, owb}, eo[k[1:0]]);
		end
	endtask : t_formats

	// every de-emphasis rate with polarity, roll-off and clock halving
	task automatic t_interface();
		for (int r = 0; r < 4; r++) begin
			fmc_host_model_inst.send({5'h00, 2'h3, 1'b0, r[1:0], ~r[0], 1'b0, r[1], 1'b0, r[0], 1'b0});
			fmc_host_model_inst.idle();
			chk_val({14'h0000, sfr}, {14'h0000, r[1:0]});
			chk_bit(pol, r[0]);
			chk_bit(slo, r[1]);
			chk_bit(ckh, ~r[0]);
			chk_bit(com, 1'b0);
			@(negedge core_clk);
			chk_val({14'h0000, drt}, {14'h0000, r[1:0]});
			chk_bit(drr, r == 1);
		end
	endtask : t_interface

	// reserved positions set on purpose must change nothing
	task automatic t_reserved();
		fmc_host_model_inst.send_raw(16'hF95A);
		fmc_host_model_inst.send_raw(16'hFDA5);
		fmc_host_model_inst.idle();
		chk_levels(8'h5A, 8'h77);
		chk_val({14'h0000, owf}, 16'h0001);
		chk_val({14'h0000, iwf}, 16'h0000);
		chk_bit(dee, 1'b0);
		chk_bit(ssn, 1'b1);
	endtask : t_reserved

	// ==========================================================
	// verdict, reached from the main sequence or the watchdog
	task automatic conclude();
		$display("checks=%0d mismatches=%0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : conclude

	// main sequence: reset held 20 cycles, then the scenarios
	initial begin
		repeat (20) @(negedge core_clk);
		sys_rst <= 1'b0;
		@(negedge core_clk);
		t_reset();
		t_independent();
		t_common();
		t_formats();
		t_interface();
		t_reserved();
		conclude();
	end

	// watchdog: the run needs under a hundred cycles, allow 4000
	initial begin
		#200000;
		fails++;
		conclude();
	end
endmodule : testbench
